// *** src/spm_regs.svh ***
// Register addresses, field positions, reset values and timing counts of the sleep power manager.
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// ==========================================================================
// Register addresses
`define SPM_CLOCK_GATE_ADDR   32'h4000_4038
`define SPM_CONTROL_ADDR      32'h4000_4000
`define SPM_WAKE_STATUS_ADDR  32'h4000_4004
`define SPM_STATE_ADDR        32'h4000_4008

// ==========================================================================
// Field positions
`define SPM_GATE_SC1_BIT      1
`define SPM_GATE_RSVD_BIT     5
`define SPM_GATE_MASK         32'h0000_0022
`define SPM_CTRL_DEEP_SEL_BIT 0
`define SPM_CTRL_OSC_OFF_BIT  1
`define SPM_CTRL_XTAL_BIT     2
`define SPM_CTRL_MASK         32'h0000_0007
`define SPM_WAKE_SRC_COUNT    9
`define SPM_WAKE_GPIO         0
`define SPM_WAKE_SERIAL       1
`define SPM_WAKE_IRQ_LINE     2
`define SPM_WAKE_DBG_REQ      3
`define SPM_WAKE_SYS_REQ      4
`define SPM_WAKE_CMP_A        5
`define SPM_WAKE_CMP_B        6
`define SPM_WAKE_WRAP         7
`define SPM_WAKE_CORE         8

// ==========================================================================
// Reset values and timing
`define SPM_CLOCK_GATE_RESET  32'h0000_0000
`define SPM_CONTROL_RESET     32'h0000_0000
`define SPM_CPU_RESET_CYCLES  4

`endif

// *** src/spm_pkg.sv ***
// Types shared by the sleep power manager and its debugger end.
package spm_pkg;
  typedef enum logic [2:0] {
    st_run,
    st_idle,
    st_pre,
    st_emu,
    st_deep,
    st_wake
  } spm_state_t;

  typedef enum logic [1:0] {
    dg_idle,
    dg_wait_ack
  } spm_dbg_state_t;
endpackage

// *** src/spm_dbg_if.sv ***
// Debug port link between the debugger end and the power manager end.
`timescale 1ns/10ps
`default_nettype none
interface spm_dbg_if;
  logic system_powerup_request;
  logic debug_powerup_request;
  logic system_powerup_ack;
  logic debug_powerup_ack;
  logic wake_core_write;

  modport dev (
    input  system_powerup_request,
    input  debug_powerup_request,
    input  wake_core_write,
    output system_powerup_ack,
    output debug_powerup_ack
  );

  modport dbg (
    output system_powerup_request,
    output debug_powerup_request,
    output wake_core_write,
    input  system_powerup_ack,
    input  debug_powerup_ack
  );
endinterface
`default_nettype wire

// *** src/spm_sync3.sv ***
// Three-stage pin synchroniser with agreement filter and change pulse per bit.
`timescale 1ns/10ps
`default_nettype none
module spm_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] level_o,
  output var  logic [W-1:0] change_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1_reg[i]  <= 1'b0;
          s2_reg[i]  <= 1'b0;
          s3_reg[i]  <= 1'b0;
          level_o[i] <= 1'b0;
        end else begin
          s1_reg[i] <= async_i[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          // A new level is taken only once the two later stages agree.
          if (s2_reg[i] == s3_reg[i]) begin
            level_o[i] <= s3_reg[i];
          end
        end
      end
      assign change_o[i] = (s2_reg[i] == s3_reg[i]) && (s3_reg[i] != level_o[i]);
    end
  endgenerate
endmodule
`default_nettype wire

// *** src/spm_manager.sv ***
// Sleep power manager: sleep modes, core power and reset gating, wake recording.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"
module spm_manager
  import spm_pkg::*;
#(
  parameter int unsigned GPIO_W       = 16,
  parameter int unsigned RESET_CYCLES = `SPM_CPU_RESET_CYCLES
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  spm_dbg_if.dev                 dbg,
  input  wire logic [31:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output var  logic [31:0]       rdata_o,
  input  wire logic              wait_for_interrupt_insn_i,
  input  wire logic              irq_i,
  input  wire logic [GPIO_W-1:0] gpio_i,
  input  wire logic              serial_one_wake_pin_i,
  input  wire logic              remappable_interrupt_line_i,
  input  wire logic              timer_cmp_a_i,
  input  wire logic              timer_cmp_b_i,
  input  wire logic              timer_wrap_i,
  output var  logic              cpu_halt_o,
  output var  logic              core_power_on_o,
  output var  logic              cpu_reset_o,
  output var  logic              periph_reset_o,
  output var  logic              sleep_timer_run_o,
  output var  logic              low_freq_rc_oscillator_on_o,
  output var  logic              serial_one_clock_en_o
);
  localparam int unsigned NSRC = `SPM_WAKE_SRC_COUNT;
  localparam int unsigned CW   = $clog2(RESET_CYCLES + 1);

  spm_state_t    state_reg;
  spm_state_t    state_next;
  logic          osc_off_reg;
  logic          osc_off_next;
  logic [CW-1:0] count_reg;
  logic [31:0]   clock_gate_reg;
  logic [31:0]   control_reg;
  logic [NSRC-1:0] wake_status_reg;
  logic          dbg_req_q_reg;
  logic          sys_req_q_reg;
  logic [GPIO_W+1:0] pin_change;
  logic [NSRC-1:0] events;
  logic          timer_ok;
  logic          wake_deep;
  logic          wake_emu;
  logic          deep_off;

  // ==========================================================================
  // Wake sources
  spm_sync3 #(
    .W (GPIO_W + 2)
  ) u_sync (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .async_i  ({remappable_interrupt_line_i, serial_one_wake_pin_i, gpio_i}),
    .level_o  (),
    .change_o (pin_change)
  );

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dbg_req_q_reg <= 1'b0;
      sys_req_q_reg <= 1'b0;
    end else begin
      dbg_req_q_reg <= dbg.debug_powerup_request;
      sys_req_q_reg <= dbg.system_powerup_request;
    end
  end

  always_comb begin
    events                      = '0;
    events[`SPM_WAKE_GPIO]      = |pin_change[GPIO_W-1:0];
    events[`SPM_WAKE_SERIAL]    = pin_change[GPIO_W];
    events[`SPM_WAKE_IRQ_LINE]  = pin_change[GPIO_W+1];
    events[`SPM_WAKE_DBG_REQ]   = dbg.debug_powerup_request && !dbg_req_q_reg;
    events[`SPM_WAKE_SYS_REQ]   = dbg.system_powerup_request && !sys_req_q_reg;
    events[`SPM_WAKE_CMP_A]     = timer_cmp_a_i;
    events[`SPM_WAKE_CMP_B]     = timer_cmp_b_i;
    events[`SPM_WAKE_WRAP]      = timer_wrap_i;
    events[`SPM_WAKE_CORE]      = dbg.wake_core_write;
  end

  // Timer wakes need a running timer: oscillator kept, or crystal clocking it.
  assign timer_ok  = !osc_off_reg || control_reg[`SPM_CTRL_XTAL_BIT];
  assign wake_deep = (|events[`SPM_WAKE_SYS_REQ:`SPM_WAKE_GPIO])
                     || (timer_ok && |events[`SPM_WAKE_WRAP:`SPM_WAKE_CMP_A]);
  assign wake_emu  = |events;

  // Recorder runs in every state; a new event beats a clear in the same cycle.
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_wake
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          wake_status_reg[i] <= 1'b0;
        end else if (events[i]) begin
          wake_status_reg[i] <= 1'b1;
        end else if (wr_i && addr_i == `SPM_WAKE_STATUS_ADDR && wdata_i[i]) begin
          wake_status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Sleep sequencer
  always_comb begin
    state_next   = state_reg;
    osc_off_next = osc_off_reg;
    case (state_reg)
      st_run: begin
        if (wait_for_interrupt_insn_i) begin
          if (control_reg[`SPM_CTRL_DEEP_SEL_BIT]) begin
            state_next = st_pre;
          end else begin
            state_next = st_idle;
          end
        end
      end
      st_idle: begin
        if (irq_i) begin
          state_next = st_run;
        end
      end
      st_pre: begin
        // Nothing is cut while the debugger still touches memory.
        if (!dbg.system_powerup_request) begin
          if (dbg.debug_powerup_request) begin
            state_next = st_emu;
          end else begin
            state_next   = st_deep;
            osc_off_next = control_reg[`SPM_CTRL_OSC_OFF_BIT];
          end
        end
      end
      st_emu: begin
        if (wake_emu) begin
          state_next = st_run;
        end
      end
      st_deep: begin
        if (wake_deep) begin
          state_next   = st_wake;
          osc_off_next = 1'b0;
        end
      end
      st_wake: begin
        if (count_reg == '0) begin
          state_next = st_run;
        end
      end
      default: begin
        state_next = st_run;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg   <= st_run;
      osc_off_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      osc_off_reg <= osc_off_next;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= '0;
    end else if (state_next == st_wake && state_reg != st_wake) begin
      count_reg <= CW'(RESET_CYCLES - 1);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  // ==========================================================================
  // Power, reset and clock outputs
  assign deep_off = (state_next == st_deep) && osc_off_next;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_halt_o                  <= 1'b0;
      core_power_on_o             <= 1'b1;
      cpu_reset_o                 <= 1'b0;
      periph_reset_o              <= 1'b0;
      sleep_timer_run_o           <= 1'b1;
      low_freq_rc_oscillator_on_o <= 1'b1;
    end else begin
      cpu_halt_o        <= state_next == st_idle || state_next == st_pre
                           || state_next == st_emu;
      core_power_on_o   <= state_next != st_deep;
      cpu_reset_o       <= state_next == st_wake;
      // Trace, watchpoint, patch and interrupt-controller logic is never reset here.
      periph_reset_o    <= state_next == st_emu || state_next == st_wake;
      sleep_timer_run_o <= !(deep_off && !control_reg[`SPM_CTRL_XTAL_BIT]);
      low_freq_rc_oscillator_on_o <= !deep_off;
    end
  end

  // Acks are withheld while the core is down or in reset, which stalls the debugger.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dbg.system_powerup_ack <= 1'b0;
      dbg.debug_powerup_ack  <= 1'b0;
    end else begin
      dbg.system_powerup_ack <= dbg.system_powerup_request
                                && state_next != st_deep && state_next != st_wake;
      dbg.debug_powerup_ack  <= dbg.debug_powerup_request
                                && state_next != st_deep && state_next != st_wake;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clock_gate_reg <= `SPM_CLOCK_GATE_RESET;
      control_reg    <= `SPM_CONTROL_RESET;
    end else if (wr_i) begin
      if (addr_i == `SPM_CLOCK_GATE_ADDR) begin
        clock_gate_reg <= wdata_i & `SPM_GATE_MASK;
      end
      if (addr_i == `SPM_CONTROL_ADDR) begin
        control_reg <= wdata_i & `SPM_CTRL_MASK;
      end
    end
  end

  // A stopped clock freezes the peripheral's registers: writes are lost, reads hold.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_one_clock_en_o <= 1'b1;
    end else begin
      serial_one_clock_en_o <= !clock_gate_reg[`SPM_GATE_SC1_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `SPM_CLOCK_GATE_ADDR:  rdata_o <= clock_gate_reg;
        `SPM_CONTROL_ADDR:     rdata_o <= control_reg;
        `SPM_WAKE_STATUS_ADDR: rdata_o <= 32'(wake_status_reg);
        `SPM_STATE_ADDR:       rdata_o <= {27'h000_0000, osc_off_reg, 1'b0, state_reg};
        default:               rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// *** src/spm_debugger.sv ***
// Debugger end: holds the two power-up requests and stalls accesses until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module spm_debugger
  import spm_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rstn_i,
  spm_dbg_if.dbg    dbg,
  input  wire logic connect_i,
  input  wire logic disconnect_i,
  input  wire logic sys_on_i,
  input  wire logic sys_off_i,
  input  wire logic access_i,
  input  wire logic wake_core_i,
  output var  logic busy_o,
  output var  logic access_done_o
);
  spm_dbg_state_t state_reg;
  logic           auto_sys_reg;

  // The debug request moves only on explicit commands; only power-on reset clears it otherwise.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dbg.debug_powerup_request <= 1'b0;
    end else if (connect_i) begin
      dbg.debug_powerup_request <= 1'b1;
    end else if (disconnect_i) begin
      dbg.debug_powerup_request <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dbg.wake_core_write <= 1'b0;
    end else begin
      dbg.wake_core_write <= wake_core_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg                  <= dg_idle;
      auto_sys_reg               <= 1'b0;
      access_done_o              <= 1'b0;
      busy_o                     <= 1'b0;
      dbg.system_powerup_request <= 1'b0;
    end else begin
      access_done_o <= 1'b0;
      case (state_reg)
        dg_idle: begin
          if (access_i) begin
            state_reg                  <= dg_wait_ack;
            busy_o                     <= 1'b1;
            auto_sys_reg               <= !dbg.system_powerup_request;
            dbg.system_powerup_request <= 1'b1;
          end else if (sys_on_i) begin
            dbg.system_powerup_request <= 1'b1;
          end else if (sys_off_i) begin
            dbg.system_powerup_request <= 1'b0;
          end
        end
        dg_wait_ack: begin
          // The access stays stalled until the device has its core up.
          if (dbg.system_powerup_ack) begin
            state_reg     <= dg_idle;
            busy_o        <= 1'b0;
            access_done_o <= 1'b1;
            if (auto_sys_reg) begin
              dbg.system_powerup_request <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= dg_idle;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/spm_link_props.sv ***
// Checker of the debug link between the debugger end and the power manager end.
`timescale 1ns/10ps
`default_nettype none
module spm_link_props (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic system_powerup_request,
  input wire logic debug_powerup_request,
  input wire logic system_powerup_ack,
  input wire logic debug_powerup_ack,
  input wire logic wake_core_write
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // ==========================================================================
  // Request and acknowledge
  sequence s_sys_up;
    $rose(system_powerup_request);
  endsequence
  sequence s_dbg_up;
    $rose(debug_powerup_request);
  endsequence

  a_sys_ack_drop: assert property (!system_powerup_request |=> !system_powerup_ack)
    else $error("system ack stands without its request");
  a_dbg_ack_drop: assert property (!debug_powerup_request |=> !debug_powerup_ack)
    else $error("debug ack stands without its request");
  // A request raised in deep sleep has to wake the core and be granted within the bound.
  a_sys_ack_grant: assert property (s_sys_up |-> ##[1:16] (system_powerup_ack || !system_powerup_request))
    else $error("system request not granted in time");
  a_dbg_ack_grant: assert property (s_dbg_up |-> ##[1:16] (debug_powerup_ack || !debug_powerup_request))
    else $error("debug request not granted in time");
  a_sys_ack_cause: assert property ($rose(system_powerup_ack) |-> $past(system_powerup_request))
    else $error("system ack rose with no request");
  a_sys_ack_hold: assert property (system_powerup_ack && system_powerup_request |=> system_powerup_ack)
    else $error("core went down under a system request");
  a_dbg_ack_hold: assert property (debug_powerup_ack && debug_powerup_request |=> debug_powerup_ack)
    else $error("core went down under a debug request");
  a_wake_pulse_one: assert property (wake_core_write |=> !wake_core_write)
    else $error("wake core write longer than one cycle");
endmodule
`default_nettype wire

// *** test/sleep_power_manager_tb.sv ***
// Self-checking bench of the power manager and debugger ends joined by their link.
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"
module sleep_power_manager_tb import spm_pkg::*;;
  localparam int RST = 3;
  logic clock_i = 0, rstn_i = 0, wr = 0, rd = 0, wait_for_interrupt_insn = 0, irq = 0, pser = 0, pirq = 0;
  logic cmpa = 0, cmpb = 0, wrap = 0, con = 0, dis = 0, son = 0, soff = 0, acc = 0, wcore = 0;
  logic [31:0] addr = 0, wdata = 0, rdata, rv, d, seed = 32'h42e96d81;
  logic [15:0] gpio = 0;
  logic halt, core_on, cpu_rst, per_rst, tmr_run, rc_on, sc1_en, busy, done;
  int fail_count = 0, cmp_count = 0, rst_len = 0, i, k;

  spm_dbg_if link();
  spm_manager #(.GPIO_W(16), .RESET_CYCLES(RST)) spm_manager_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .dbg(link), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .wait_for_interrupt_insn_i(wait_for_interrupt_insn), .irq_i(irq),
    .gpio_i(gpio), .serial_one_wake_pin_i(pser), .remappable_interrupt_line_i(pirq),
    .timer_cmp_a_i(cmpa), .timer_cmp_b_i(cmpb), .timer_wrap_i(wrap), .cpu_halt_o(halt),
    .core_power_on_o(core_on), .cpu_reset_o(cpu_rst), .periph_reset_o(per_rst),
    .sleep_timer_run_o(tmr_run), .low_freq_rc_oscillator_on_o(rc_on),
    .serial_one_clock_en_o(sc1_en));
  spm_debugger spm_debugger_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .dbg(link), .connect_i(con), .disconnect_i(dis),
    .sys_on_i(son), .sys_off_i(soff), .access_i(acc), .wake_core_i(wcore),
    .busy_o(busy), .access_done_o(done));
  spm_link_props spm_link_props_inst (
    .clock_i(clock_i), .rstn_i(rstn_i),
    .system_powerup_request(link.system_powerup_request),
    .debug_powerup_request(link.debug_powerup_request),
    .system_powerup_ack(link.system_powerup_ack),
    .debug_powerup_ack(link.debug_powerup_ack), .wake_core_write(link.wake_core_write));

  always #50 clock_i = ~clock_i;
  // Counts the cycles of the CPU reset; cleared by the main sequence only while it is low.
  always @(posedge clock_i) if (cpu_rst === 1'b1) rst_len <= rst_len + 1;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] gate_exp(logic [31:0] v);
    return v & `SPM_GATE_MASK;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(logic [31:0] a, logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clock_i);
    wr <= 0;
  endtask
  task automatic rd_reg(logic [31:0] a);
    @(posedge clock_i);
    addr <= a;
    rd <= 1;
    @(posedge clock_i);
    rd <= 0;
    #1 rv = rdata;
  endtask
  // Codes 0 to 8 follow the wake status bit order; higher codes are other requests.
  task automatic fire(int c);
    @(posedge clock_i);
    case (c)
      0: gpio <= gpio ^ (16'h0001 << (xs() & 32'h0000_000f));
      1: pser <= ~pser;
      2: pirq <= ~pirq;
      3: con <= 1;
      4: son <= 1;
      5: cmpa <= 1;
      6: cmpb <= 1;
      7: wrap <= 1;
      8: wcore <= 1;
      9: wait_for_interrupt_insn <= 1;
      10: dis <= 1;
      11: soff <= 1;
      default: acc <= 1;
    endcase
    @(posedge clock_i);
    {con, son, cmpa, cmpb, wrap, wcore, wait_for_interrupt_insn, dis, soff, acc} <= '0;
  endtask
  task automatic go(spm_state_t s);
    for (int j = 0; j < 40; j++) begin
      rd_reg(`SPM_STATE_ADDR);
      if (rv[2:0] === s) break;
    end
    chk("state", {29'h0, rv[2:0]}, {29'h0, s});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1;
    rd_reg(`SPM_CLOCK_GATE_ADDR);
    chk("gate reset", rv, `SPM_CLOCK_GATE_RESET);
    rd_reg(32'h4000_4ffc);
    chk("unmapped read", rv, 32'h0000_0000);
    for (k = 0; k < 5; k++) begin
      d = (k == 0) ? 32'hffff_ffff : xs();
      // The reserved bit is written back as last read; serial one never has traffic here.
      d[`SPM_GATE_RSVD_BIT] = rv[`SPM_GATE_RSVD_BIT];
      wr_reg(`SPM_CLOCK_GATE_ADDR, d);
      rd_reg(`SPM_CLOCK_GATE_ADDR);
      chk("gate", rv, gate_exp(d));
      chk("serial one clock", sc1_en, {31'h0, !d[`SPM_GATE_SC1_BIT]});
    end
    wr_reg(`SPM_CONTROL_ADDR, 32'h0000_0000);
    fire(9);
    go(st_idle);
    chk("idle halt", halt, 1);
    chk("idle core", core_on, 1);
    chk("idle resets", {cpu_rst, per_rst}, 0);
    @(posedge clock_i) irq <= 1;
    go(st_run);
    @(posedge clock_i) irq <= 0;
    for (k = 0; k < 8; k++) begin
      wr_reg(`SPM_WAKE_STATUS_ADDR, 32'h0000_01ff);
      wr_reg(`SPM_CONTROL_ADDR, 32'h0000_0001);
      fire(9);
      go(st_deep);
      chk("deep core", core_on, 0);
      chk("deep timer", tmr_run, 1);
      rst_len = 0;
      fire(k);
      go(st_run);
      chk("wake core", core_on, 1);
      chk("cpu reset length", rst_len, RST);
      rd_reg(`SPM_WAKE_STATUS_ADDR);
      chk("wake record", rv[k], 1);
      if (k == 3) fire(10);
      if (k == 4) fire(11);
    end
    wr_reg(`SPM_CONTROL_ADDR, 32'h0000_0003);
    fire(9);
    go(st_deep);
    chk("osc off timer", {tmr_run, rc_on}, 0);
    for (k = 5; k < 9; k++) fire(k);
    go(st_deep);
    chk("still off", core_on, 0);
    fire(0);
    go(st_run);
    chk("osc restart", rc_on, 1);
    wr_reg(`SPM_CONTROL_ADDR, 32'h0000_0007);
    fire(9);
    go(st_deep);
    chk("crystal timer", {tmr_run, rc_on}, 2);
    fire(6);
    go(st_run);
    chk("crystal wake core", core_on, 1);
    fire(3);
    wr_reg(`SPM_CONTROL_ADDR, 32'h0000_0001);
    fire(9);
    go(st_emu);
    chk("emu core", core_on, 1);
    chk("emu periph", {halt, per_rst}, 3);
    rst_len = 0;
    fire(8);
    go(st_run);
    chk("emu no cpu reset", rst_len, 0);
    chk("debug request kept", link.debug_powerup_request, 1);
    fire(10);
    fire(4);
    fire(9);
    go(st_pre);
    repeat (10) @(posedge clock_i);
    go(st_pre);
    chk("pre power", {core_on, per_rst, halt}, 5);
    fire(11);
    go(st_deep);
    fire(12);
    #1 chk("access busy", busy, 1);
    i = 0;
    while (done !== 1'b1 && i < 60) begin
      @(posedge clock_i);
      #1 i++;
    end
    chk("access granted", done, 1);
    chk("access not busy", busy, 0);
    chk("access core", core_on, 1);
    go(st_run);
    test_done();
  end
endmodule
`default_nettype wire
